// File: common/ftm_pkg.sv
// Package of constants and types for the film transport mode logic
package ftm_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_MODE   = 8'h04;
	localparam logic [7:0] ADDR_PARAM  = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_FREQ   = 8'h10;
	// Control fields
	localparam int CTRL_RELAY_LSB = 0;
	localparam int CTRL_ONLINE    = 2;
	// Parameter register fields
	localparam int PARAM_FPS_LSB   = 0;
	localparam int PARAM_ACCEL_LSB = 8;
	localparam int PARAM_WIND_LSB  = 16;
	// Default parameters
	localparam logic [7:0] FPS_NTSC    = 8'h18;
	localparam logic [7:0] FPS_PAL     = 8'h19;
	localparam logic [7:0] ACCEL_SLOW  = 8'h20;
	localparam logic [7:0] ACCEL_STD   = 8'h08;
	localparam logic [7:0] WIND_SLOW   = 8'h0C;
	localparam logic [7:0] WIND_STD    = 8'h05;
	// Serial link: valid message must come within this window to keep indicator lit
	localparam int LINK_TIMEOUT_MS     = 1;
	localparam int CLK_HZ              = 10_000_000;
	localparam int LINK_TIMEOUT_CYC    = LINK_TIMEOUT_MS * (CLK_HZ / 1000);
	// Generator phase accumulator width and sync step per frame rate unit
	localparam int ACC_W               = 24;
	localparam logic [15:0] STEP_SCALE = 16'h0010;

	typedef enum logic [2:0] {
		FTM_STOP, FTM_FWD, FTM_REV, FTM_FFWD, FTM_FREV, FTM_CRAWL
	} ftm_mode_e;

	typedef enum logic [2:0] {
		FTM_F48, FTM_F96, FTM_F240, FTM_F480, FTM_F600, FTM_F1200, FTM_F2400
	} ftm_freq_e;

	typedef enum logic [1:0] {
		FTM_RELAY_NORMAL, FTM_RELAY_OPT1, FTM_RELAY_OPT2, FTM_RELAY_OPT3
	} ftm_relay_e;

	typedef struct packed {
		logic [7:0] fps;
		logic [7:0] accel;
		logic [7:0] wind;
	} ftm_param_s;

	typedef struct packed {
		logic stop;
		logic fwd;
		logic rev;
		logic ffwd;
		logic frev;
		logic rec;
	} ftm_tally_s;
endpackage

// File: src/ftm_transport.sv
// Film transport mode logic: tallies, mute relay, parameters, biphase generator
//
// Our own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ftm_transport (
	// Clock and reset
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	// AHB-Lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic      [31:0]          hrdata,
	output logic                      hreadyout,
	output logic                      hresp,
	// Mode command sources
	input  wire logic                 editor_cmd_valid,
	input  wire ftm_pkg::ftm_mode_e   editor_cmd_mode,
	input  wire logic                 editor_addressed,
	input  wire logic                 editor_msg_valid,
	input  wire logic [5:0]           motion_switch,
	input  wire logic                 record_cmd,
	// Reference and lock state
	input  wire logic                 pal_detected,
	input  wire logic                 lock_achieved,
	input  wire logic                 clear_key,
	// Outputs to the transport
	output ftm_pkg::ftm_tally_s       tally,
	output logic                      mute_relay,
	output logic                      biphase_a,
	output logic                      biphase_b,
	output logic                      link_indicator,
	output logic                      init_config
);
	import ftm_pkg::*;

	// Refuse an accumulator narrower than 3 bits: two quadrant bits and one below them
	if (ACC_W < 3) begin : g_acc_check
		$error("phase accumulator too narrow for quadrature");
	end

	ftm_mode_e  mode;
	ftm_mode_e  next_mode;
	ftm_freq_e  freq;
	ftm_relay_e relay_opt;
	ftm_param_s param;
	logic       online;
	logic       boot_done;
	logic [15:0] speed;
	logic [15:0] target;
	logic [ACC_W-1:0] phase;
	logic [31:0] link_cnt;
	logic       ph_dir;
	logic       wr_pend;
	logic [7:0] wr_addr;

	// Defaults for a frequency selection
	function automatic ftm_param_s defaults(input ftm_freq_e f, input logic pal);
		ftm_param_s p;
		p.fps   = pal ? FPS_PAL : FPS_NTSC;
		p.accel = (f == FTM_F48) ? ACCEL_SLOW : ACCEL_STD;
		p.wind  = (f == FTM_F48) ? WIND_SLOW : WIND_STD;
		return p;
	endfunction

	// Mode command arbitration: editor wins over local switches when online
	always_comb begin
		next_mode = mode;
		if (editor_cmd_valid && online) begin
			next_mode = editor_cmd_mode;
		end else if (motion_switch[0]) begin
			next_mode = FTM_STOP; // Stop switch first among the switches; an editor command while online still overrides it
		end else if (motion_switch[1]) begin
			next_mode = FTM_FWD;
		end else if (motion_switch[2]) begin
			next_mode = FTM_REV;
		end else if (motion_switch[3]) begin
			next_mode = FTM_FFWD;
		end else if (motion_switch[4]) begin
			next_mode = FTM_FREV;
		end else if (motion_switch[5]) begin
			next_mode = FTM_CRAWL;
		end
	end

	// Registered transport mode state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode <= FTM_STOP;
		end else begin
			mode <= next_mode;
		end
	end

	// Tallies follow the mode without waiting for the generator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tally <= '0;
		end else begin
			tally.stop <= (next_mode == FTM_STOP);
			tally.fwd  <= (next_mode == FTM_FWD) || (next_mode == FTM_CRAWL);
			tally.rev  <= (next_mode == FTM_REV);
			tally.ffwd <= (next_mode == FTM_FFWD);
			tally.frev <= (next_mode == FTM_FREV);
			tally.rec  <= record_cmd;
		end
	end

	// Generator target speed; crawl runs at a quarter of sync
	always_comb begin
		case (mode)
			FTM_FWD, FTM_REV:   target = {8'h00, param.fps};
			FTM_FFWD, FTM_FREV: target = 16'(param.fps * param.wind);
			FTM_CRAWL:          target = {10'h000, param.fps[7:2]};
			default:            target = 16'h0000;
		endcase
	end

	// Speed ramp; direction changes only once stopped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			speed  <= 16'h0000;
			ph_dir <= 1'b0;
		end else begin
			if ((mode == FTM_REV || mode == FTM_FREV) != ph_dir) begin
				if (speed > {8'h00, param.accel}) begin
					speed <= speed - {8'h00, param.accel};
				end else begin
					speed  <= 16'h0000;
					ph_dir <= (mode == FTM_REV || mode == FTM_FREV);
				end
			end else if (speed + {8'h00, param.accel} < target) begin
				speed <= speed + {8'h00, param.accel};
			end else if (speed > target + {8'h00, param.accel}) begin
				speed <= speed - {8'h00, param.accel};
			end else begin
				speed <= target;
			end
		end
	end

	// Mute relay decoded from next_mode, the same as the tallies
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mute_relay <= 1'b0;
		end else begin
			mute_relay <= (next_mode == FTM_FFWD || next_mode == FTM_REV || next_mode == FTM_FREV)
				|| (relay_opt != FTM_RELAY_NORMAL && next_mode == FTM_FWD
				&& (speed != target || !lock_achieved));
		end
	end

	// Phase accumulator; quadrant gives quadrature outputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			phase     <= '0;
			biphase_a <= 1'b0;
			biphase_b <= 1'b0;
		end else begin
			if (ph_dir) begin
				phase <= phase - ACC_W'(speed * STEP_SCALE * (freq + 1));
			end else begin
				phase <= phase + ACC_W'(speed * STEP_SCALE * (freq + 1));
			end
			// Gray-coded quadrant, so only one phase moves per quadrant step
			biphase_a <= phase[ACC_W-1] ^ phase[ACC_W-2];
			biphase_b <= phase[ACC_W-1]; // Rises a quarter cycle after A going forward
		end
	end

	// Link indicator with a short hold-off against message gaps
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			link_cnt       <= 32'h0000_0000;
			link_indicator <= 1'b0;
		end else begin
			if (editor_addressed && editor_msg_valid) begin
				link_cnt <= 32'(LINK_TIMEOUT_CYC);
			end else if (link_cnt != 0) begin
				link_cnt <= link_cnt - 32'h0000_0001;
			end
			link_indicator <= editor_addressed && (editor_msg_valid || link_cnt > 1);
		end
	end

	// Bus address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else if (hready) begin
			wr_pend <= hsel && htrans[1] && hwrite;
			wr_addr <= haddr[7:0];
		end
	end

	// Configuration registers; strap caught on the first clock after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			boot_done   <= 1'b0;
			init_config <= 1'b0;
			freq        <= FTM_F48;
			relay_opt   <= FTM_RELAY_NORMAL;
			online      <= 1'b0;
			param       <= '0;
		end else if (!boot_done) begin
			boot_done <= 1'b1;
			if (clear_key) begin
				init_config <= 1'b1;
				freq        <= FTM_F48;
				relay_opt   <= FTM_RELAY_NORMAL;
				param       <= defaults(FTM_F48, pal_detected);
			end else begin
				param <= defaults(freq, pal_detected);
			end
		end else if (wr_pend) begin
			case (wr_addr)
				ADDR_CTRL: begin
					relay_opt <= ftm_relay_e'(hwdata[CTRL_RELAY_LSB +: 2]);
					online    <= hwdata[CTRL_ONLINE];
				end
				ADDR_FREQ: begin
					if (hwdata[2:0] <= 3'(FTM_F2400)) begin
						if (ftm_freq_e'(hwdata[2:0]) != freq) begin
							param <= defaults(ftm_freq_e'(hwdata[2:0]), pal_detected);
						end
						freq        <= ftm_freq_e'(hwdata[2:0]);
						init_config <= 1'b0;
					end
				end
				ADDR_PARAM: begin
					param.fps   <= hwdata[PARAM_FPS_LSB +: 8];
					param.accel <= hwdata[PARAM_ACCEL_LSB +: 8];
					param.wind  <= hwdata[PARAM_WIND_LSB +: 8];
				end
				default: ; // Unmapped offsets ignore writes
			endcase
		end
	end

	// Read data and response; zero wait states
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else if (hready && hsel && htrans[1] && !hwrite) begin
			case (haddr[7:0])
				ADDR_CTRL:   hrdata <= {29'h0, online, relay_opt};
				ADDR_MODE:   hrdata <= {13'h0, tally, 2'h0, mode, 7'h00, mute_relay};
				ADDR_PARAM:  hrdata <= {8'h00, param.wind, param.accel, param.fps};
				ADDR_STATUS: hrdata <= {speed, 11'h0, ph_dir, init_config, link_indicator, lock_achieved, pal_detected};
				ADDR_FREQ:   hrdata <= {29'h0, freq};
				default:     hrdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // ftm_transport
`default_nettype wire

// File: tb/ftm_transport_sva.sv
// Checker of the mode logic port behaviour
`timescale 1ns/1ps
`default_nettype none
module ftm_transport_sva (
	// Clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// Commands seen by the block
	input wire logic [5:0]          motion_switch,
	input wire logic                record_cmd,
	input wire logic                editor_addressed,
	// Outputs watched
	input wire ftm_pkg::ftm_tally_s tally,
	input wire logic                mute_relay,
	input wire logic                biphase_a,
	input wire logic                biphase_b,
	input wire logic                link_indicator
);
	import ftm_pkg::*;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Switch presses show on tally and relay one edge later
	property p_stop; motion_switch[0] |=> tally.stop && !mute_relay; endproperty
	a_stop: assert property (p_stop) else $error("stop press not shown");
	property p_fwd; motion_switch == 6'h02 |=> tally.fwd && !tally.stop; endproperty
	a_fwd: assert property (p_fwd) else $error("forward press not shown");
	property p_ffwd; motion_switch == 6'h08 |=> tally.ffwd && mute_relay; endproperty
	a_ffwd: assert property (p_ffwd) else $error("fast forward press wrong");
	property p_frev; motion_switch == 6'h10 |=> tally.frev && mute_relay; endproperty
	a_frev: assert property (p_frev) else $error("fast reverse press wrong");
	property p_rec; record_cmd |=> tally.rec; endproperty
	a_rec: assert property (p_rec) else $error("record tally missing");
	// Only one motion tally may be lit at a time
	property p_onehot; $onehot0({tally.stop, tally.fwd, tally.rev, tally.ffwd, tally.frev}); endproperty
	a_onehot: assert property (p_onehot) else $error("several motion tallies lit");
	// Indicator drops once the editor stops addressing us
	property p_link; !editor_addressed ##1 !editor_addressed |-> !link_indicator; endproperty
	a_link: assert property (p_link) else $error("link lit while unaddressed");
	// Quadrature: the two phases never switch in the same cycle
	property p_quad; !($changed(biphase_a) && $changed(biphase_b)); endproperty
	a_quad: assert property (p_quad) else $error("both phases toggled");
	c_ffwd: cover property (motion_switch == 6'h08);
	c_rec: cover property (record_cmd);
	c_link: cover property (link_indicator);
endmodule // ftm_transport_sva
bind ftm_transport ftm_transport_sva ftm_transport_sva_i (.hclk, .hresetn, .motion_switch, .record_cmd,
	.editor_addressed, .tally, .mute_relay, .biphase_a, .biphase_b, .link_indicator);
`default_nettype wire

// File: tb/ftm_film_model.sv
// Model of the film transport following the biphase lines
`timescale 1ns/1ps
`default_nettype none
module ftm_film_model #(
	parameter int LOCK_EDGES = 4
) (
	// Clock and reset
	input wire logic                hclk,
	input wire logic                hresetn,
	// From the block
	input wire logic                biphase_a,
	input wire logic                biphase_b,
	input wire ftm_pkg::ftm_tally_s tally,
	// Back to the block
	output logic                    lock_achieved,
	output logic                    moving_fwd
);
	import ftm_pkg::*;
	logic       a_q;
	logic [7:0] edges;
	// Count tach edges; a stopped film loses lock at once
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			a_q <= 1'b0;
			edges <= 8'h00;
			moving_fwd <= 1'b0;
		end else begin
			a_q <= biphase_a;
			if (tally.stop) begin
				edges <= 8'h00;
			end else if (biphase_a && !a_q && edges != 8'hFF) begin
				edges <= edges + 8'h01;
				moving_fwd <= !biphase_b;
			end
		end
	end
	// A larger count makes a slow-locking transport
	assign lock_achieved = (edges >= LOCK_EDGES[7:0]);
endmodule // ftm_film_model
`default_nettype wire

// File: tb/ftm_transport_tb.sv
// Self-checking bench of the film transport mode logic
`timescale 1ns/1ps
`default_nettype none
module ftm_transport_tb;
	import ftm_pkg::*;
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
	logic [1:0] htrans = 2'h0;
	logic hreadyout, hresp, mute_relay, biphase_a, biphase_b, link_indicator, init_config, lock_achieved;
	logic moving_fwd;
	logic editor_cmd_valid = 1'b0, editor_addressed = 1'b0, editor_msg_valid = 1'b0;
	logic record_cmd = 1'b0, pal_detected = 1'b0, clear_key = 1'b0;
	logic [5:0] motion_switch = 6'h00;
	ftm_mode_e editor_cmd_mode = FTM_STOP;
	ftm_tally_s tally;
	int fails = 0, samples_checked = 0;
	// Rows: switch pressed, expected tally, expected relay
	localparam logic [12:0] ROWS [6] = '{{6'h01, 6'h20, 1'b0}, {6'h02, 6'h10, 1'b0}, {6'h04, 6'h08, 1'b1},
		{6'h08, 6'h04, 1'b1}, {6'h10, 6'h02, 1'b1}, {6'h20, 6'h10, 1'b0}};
	always #50 hclk = ~hclk;
	ftm_transport ftm_transport_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .editor_cmd_valid, .editor_cmd_mode, .editor_addressed,
		.editor_msg_valid, .motion_switch, .record_cmd, .pal_detected, .lock_achieved, .clear_key, .tally,
		.mute_relay, .biphase_a, .biphase_b, .link_indicator, .init_config);
	ftm_film_model ftm_film_model_i (.hclk, .hresetn, .biphase_a, .biphase_b, .tally, .lock_achieved,
		.moving_fwd);
	// Compare one value and count it
	task automatic check(input string n, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", n, exp, got);
		end
	endtask
	// One AHB single transfer; waits on hready with no assumed latency
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		q = hrdata;
	endtask
	task automatic wait_n(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic test_done;
		if (fails == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Watchdog sized well above the whole sequence
	initial begin
		wait_n(20000);
		fails++;
		test_done;
	end
	initial begin
		wait_n(5);
		hresetn <= 1'b1;
		wait_n(2);
		check("init", {31'h0, init_config}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			motion_switch <= ROWS[i][12:7];
			wait_n(1);
			motion_switch <= 6'h00;
			wait_n(2);
			check("tally", {26'h0, tally}, {26'h0, ROWS[i][6:1]});
			check("mute", {31'h0, mute_relay}, {31'h0, ROWS[i][0]});
		end
		record_cmd <= 1'b1;
		wait_n(2);
		check("rec", {31'h0, tally.rec}, 32'h1);
		record_cmd <= 1'b0;
		bus(1'b0, ADDR_PARAM, 32'h0);
		check("param", q, 32'h000C2018);
		bus(1'b1, ADDR_FREQ, 32'h1);
		bus(1'b0, ADDR_PARAM, 32'h0);
		check("param", q, 32'h00050818);
		pal_detected <= 1'b1;
		bus(1'b1, ADDR_FREQ, 32'h6);
		bus(1'b0, ADDR_PARAM, 32'h0);
		check("param", q, 32'h00050819);
		bus(1'b1, ADDR_PARAM, 32'h00070A19);
		bus(1'b1, ADDR_FREQ, 32'h7);
		bus(1'b0, ADDR_PARAM, 32'h0);
		check("param", q, 32'h00070A19);
		bus(1'b1, ADDR_FREQ, 32'h0);
		bus(1'b0, ADDR_PARAM, 32'h0);
		check("param", q, 32'h000C2019);
		bus(1'b0, 8'h20, 32'h0);
		check("unmapped", q, 32'h0);
		check("hresp", {31'h0, hresp}, 32'h0);
		// Option 1 online: forward before lock keeps the relay on
		bus(1'b1, ADDR_CTRL, 32'h5);
		editor_cmd_mode <= FTM_FWD;
		editor_cmd_valid <= 1'b1;
		wait_n(1);
		editor_cmd_valid <= 1'b0;
		wait_n(2);
		check("ed_tally", {26'h0, tally}, 32'h10);
		check("ed_mute", {31'h0, mute_relay}, 32'h1);
		editor_addressed <= 1'b1;
		editor_msg_valid <= 1'b1;
		wait_n(1);
		editor_msg_valid <= 1'b0;
		wait_n(2);
		check("link", {31'h0, link_indicator}, 32'h1);
		editor_addressed <= 1'b0;
		wait_n(3);
		check("link", {31'h0, link_indicator}, 32'h0);
		// Fast wind at 2400 PAL: generator turns the film, the model locks and reads A leading B
		bus(1'b1, ADDR_FREQ, 32'h6);
		motion_switch <= 6'h08;
		wait_n(1);
		motion_switch <= 6'h00;
		wait_n(6000);
		check("fwd_dir", {31'h0, moving_fwd}, 32'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("lock", {31'h0, q[1]}, 32'h1);
		check("wind_speed", {16'h0, q[31:16]}, 32'h0000007D);
		// Fast reverse: generator turns round, B now leads A
		motion_switch <= 6'h10;
		wait_n(1);
		motion_switch <= 6'h00;
		wait_n(4000);
		check("rev_dir", {31'h0, moving_fwd}, 32'h0);
		bus(1'b0, ADDR_STATUS, 32'h0);
		check("rev_flag", {31'h0, q[4]}, 32'h1);
		// Forward at sync with lock held: option 1 lets the relay drop
		motion_switch <= 6'h02;
		wait_n(1);
		motion_switch <= 6'h00;
		wait_n(100);
		check("sync_mute", {31'h0, mute_relay}, 32'h0);
		// Clear key held through power-up
		clear_key <= 1'b1;
		hresetn <= 1'b0;
		wait_n(5);
		hresetn <= 1'b1;
		wait_n(2);
		clear_key <= 1'b0;
		check("init", {31'h0, init_config}, 32'h1);
		test_done;
	end
endmodule // ftm_transport_tb
`default_nettype wire
